// ==== hdl/conv_ctrl.sv ====
// Converter control: clock selection, completion flag, wake and result formatting.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Select bit 1 takes the RC clock; 0 takes the divided system clock.
// - Divided clock period is the system clock period times two times (divider plus one).
// - The sequencer resolves one result bit per conversion clock period.
// - Control runs on the selected clock; RC selection delays control writes.
// - In sleep only the RC clock lets a conversion proceed.
// - Every finished conversion sets the done flag, whatever the enable.
// - An interrupt request goes out only with enable and flag both set.
// - Sleep with conversion and peripheral enables wakes the processor without service.
// - With the global enable also set, the woken processor then takes the service.
// - Single-ended with low format bit 0: unsigned result left justified.
// - Single-ended with low format bit 1: unsigned result right justified.
// - Differential format 00: two's complement, left justified.
// - Differential format 01: two's complement right justified, sign extended.
// - Differential format 10: sign/magnitude, left justified.
// - Differential format 11: sign/magnitude, right justified.
// - Result writes store right justified; left formats read them shifted by four single-ended, by three differential, sign/magnitude keeping bit 15 in place.
// - Sign bit 0 means positive, 1 negative; right justified it is bit 15.
// - In two's complement the result's top bit gives the polarity.
// - The reference select field picks the positive reference source.
// - The divided clock follows the system clock; only RC is independent.
// - Input configuration 1 is differential, 0 single-ended ignoring the negative input.
module conv_ctrl (
    // Clock and reset
    input  wire logic                                  core_clk,
    input  wire logic                                  rst_b,
    // Configuration
    input  wire logic                                  clock_source_rc,
    input  wire logic [conv_ctrl_pkg::DIV_W-1:0]       clock_divider,
    input  wire logic                                  input_configuration,
    input  wire logic [1:0]                            result_format_mode,
    input  wire logic [conv_ctrl_pkg::REF_W-1:0]       positive_ref_select,
    // Pins
    input  wire logic                                  internal_rc_clock,
    input  wire logic                                  comparator_in,
    // Conversion control
    input  wire logic                                  conv_start,
    input  wire logic                                  sleep_mode,
    // Interrupt control
    input  wire logic                                  conversion_irq_enable,
    input  wire logic                                  peripheral_irq_enable,
    input  wire logic                                  global_irq_enable,
    input  wire logic                                  flag_clear,
    // Result write
    input  wire logic                                  result_wr,
    input  wire logic [conv_ctrl_pkg::WORD_W-1:0]      result_wdata,
    // Status and interrupt outputs
    output logic                                       conversion_done_flag,
    output logic                                       irq_request,
    output logic                                       wake_request,
    output logic                                       isr_request,
    output logic                                       conv_busy,
    // Analog side
    output logic [conv_ctrl_pkg::RES_W-1:0]            dac_trial,
    output logic [conv_ctrl_pkg::REF_W-1:0]            reference_control,
    // Result pair
    output logic [7:0]                                 result_high_byte,
    output logic [7:0]                                 result_low_byte
);
    import conv_ctrl_pkg::*;

    typedef struct packed {
        logic              ctl_rc;
        logic [DIV_W-1:0]  ctl_div;
        logic              ctl_ic;
        logic [1:0]        ctl_fm;
        logic [REF_W-1:0]  ctl_ref;
        logic              comp_meta;
        logic              comp_sync;
        conv_phase_t       phase;
        logic [3:0]        bit_idx;
        logic [RES_W-1:0]  sar;
        logic [RES_W-1:0]  trial;
        logic [WORD_W-1:0] store;
        logic              flag;
        logic              irq;
        logic              wake;
        logic              isr;
        logic              busy;
        logic [WORD_W-1:0] shown;
    } ctrl_state_t;

    ctrl_state_t       s;
    ctrl_state_t       next_s;
    logic              tick;
    logic              conv_blocked;
    logic              conv_done;
    logic [RES_W-1:0]  sar_upd;
    logic [RES_W-1:0]  diff_code;
    logic [RES_W-1:0]  magnitude;
    logic [WORD_W-1:0] done_word;
    logic              irq_cause;
    logic              wake_cause;
    logic              isr_cause;

    // Read view of the stored right-justified word.
    function automatic logic [WORD_W-1:0] present(input logic ic, input logic [1:0] fm,
                                                  input logic [WORD_W-1:0] st);
        logic [WORD_W-1:0] v;
        v = st;
        if (!fm[FM_RIGHT_BIT]) begin
            if (!ic) begin
                v = st << LEFT_SHIFT_SE;
            end else if (!fm[FM_SIGNMAG_BIT]) begin
                v = st << LEFT_SHIFT_DIFF;
            end else begin
                // The sign stays in the top bit; only the magnitude moves.
                v = {st[SIGN_POS], st[RES_W-1:0], 3'h0};
            end
        end
        return v;
    endfunction

    conv_clock_gen clock_gen (
        .core_clk          (core_clk),
        .rst_b             (rst_b),
        .sel_rc            (s.ctl_rc),
        .clock_divider     (s.ctl_div),
        .internal_rc_clock (internal_rc_clock),
        .tick              (tick)
    );

    // A system-clock conversion must wait out sleep; the RC clock keeps going.
    assign conv_blocked = sleep_mode & ~s.ctl_rc;
    assign conv_done = (s.phase == PH_CONVERT) && tick && !conv_blocked
                       && (s.bit_idx == BIT_LAST);

    always_comb begin
        sar_upd             = s.sar;
        sar_upd[s.bit_idx]  = s.comp_sync;
        // Offset binary from the array becomes two's complement.
        diff_code = {~sar_upd[RES_W-1], sar_upd[RES_W-2:0]};
        magnitude = diff_code[RES_W-1] ? (~diff_code + 12'h001) : diff_code;
        if (magnitude[RES_W-1]) begin
            magnitude = MAG_MAX;
        end
        if (!s.ctl_ic) begin
            done_word = {4'h0, sar_upd};
        end else if (!s.ctl_fm[FM_SIGNMAG_BIT]) begin
            done_word = {{4{diff_code[RES_W-1]}}, diff_code};
        end else begin
            done_word = {diff_code[RES_W-1], 4'h0, magnitude[MAG_W-1:0]};
        end
    end

    assign irq_cause  = s.flag & conversion_irq_enable;
    assign wake_cause = irq_cause & peripheral_irq_enable & sleep_mode;
    assign isr_cause  = irq_cause & peripheral_irq_enable & global_irq_enable;

    always_comb begin
        next_s           = s;
        next_s.comp_meta = comparator_in;
        next_s.comp_sync = s.comp_meta;
        // Control bits take effect only on an edge of the selected converter clock.
        if (tick) begin
            next_s.ctl_rc  = clock_source_rc;
            next_s.ctl_div = clock_divider;
            next_s.ctl_ic  = input_configuration;
            next_s.ctl_fm  = result_format_mode;
            next_s.ctl_ref = positive_ref_select;
        end
        if (result_wr) begin
            next_s.store = result_wdata;
        end
        unique case (s.phase)
            PH_IDLE: begin
                if (conv_start) begin
                    next_s.phase = PH_PENDING;
                end
            end
            PH_PENDING: begin
                if (tick && !conv_blocked) begin
                    next_s.phase   = PH_CONVERT;
                    next_s.bit_idx = BIT_FIRST;
                    next_s.sar     = '0;
                    next_s.trial   = TRIAL_MID;
                end
            end
            PH_CONVERT: begin
                if (tick && !conv_blocked) begin
                    next_s.sar = sar_upd;
                    if (s.bit_idx == BIT_LAST) begin
                        next_s.phase = PH_IDLE;
                        next_s.trial = '0;
                        next_s.store = done_word;
                    end else begin
                        next_s.bit_idx = s.bit_idx - 4'h1;
                        next_s.trial   = sar_upd | (TRIAL_MID >> (BIT_FIRST - s.bit_idx + 4'h1));
                    end
                end
            end
        endcase
        // A completion in the same cycle as a clear keeps the flag set.
        next_s.flag  = (s.flag & ~flag_clear) | conv_done;
        next_s.irq   = irq_cause;
        next_s.wake  = wake_cause;
        next_s.isr   = isr_cause;
        next_s.busy  = (s.phase != PH_IDLE);
        next_s.shown = present(s.ctl_ic, s.ctl_fm, s.store);
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign conversion_done_flag = s.flag;
    assign irq_request          = s.irq;
    assign wake_request         = s.wake;
    assign isr_request          = s.isr;
    assign conv_busy            = s.busy;
    assign dac_trial            = s.trial;
    assign reference_control    = s.ctl_ref;
    assign result_high_byte     = s.shown[WORD_W-1:8];
    assign result_low_byte      = s.shown[7:0];

    flag_set_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        conv_done |=> conversion_done_flag)
        else $error("done flag not set after a finished conversion");

    flag_hold_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (conversion_done_flag && !flag_clear) |=> conversion_done_flag)
        else $error("done flag dropped without a software clear");

    irq_gate_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        ##1 (irq_request == $past(irq_cause)))
        else $error("interrupt request not tied to enable and flag");

    wake_gate_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (sleep_mode && conversion_irq_enable && peripheral_irq_enable
         && conversion_done_flag) |=> wake_request)
        else $error("completed conversion failed to wake from sleep");

    isr_gate_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        isr_request |-> $past(global_irq_enable) && $past(conversion_done_flag))
        else $error("service request without global enable and flag");

    sleep_hold_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (sleep_mode && !s.ctl_rc && s.phase != PH_IDLE) |=> $stable(s.bit_idx))
        else $error("system clock conversion advanced during sleep");

    bit_step_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (s.phase == PH_CONVERT && !tick) |=> $stable(s.sar) && $stable(s.bit_idx))
        else $error("result bit resolved without a conversion clock");

    tc_extend_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (conv_done && !result_wr && s.ctl_ic && s.ctl_fm == 2'h1)
        |=> (s.store[15:12] == {4{s.store[11]}}))
        else $error("right justified two's complement not sign extended");

    right_se_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (!s.ctl_ic && s.ctl_fm[FM_RIGHT_BIT] && !tick)
        |=> ({result_high_byte, result_low_byte} == $past(s.store)))
        else $error("right justified read does not match stored word");

    left_diff_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (s.ctl_ic && s.ctl_fm == 2'h0 && !tick)
        |=> ({result_high_byte, result_low_byte} == ($past(s.store) << 3)))
        else $error("left justified read is not the stored word shifted by three");

endmodule

`default_nettype wire

// ==== hdl/conv_ctrl_pkg.sv ====
// Shared constants and types of the converter control block.
package conv_ctrl_pkg;

    // Field widths.
    localparam int DIV_W  = 6;
    localparam int RES_W  = 12;
    localparam int WORD_W = 16;
    localparam int REF_W  = 2;
    localparam int CNT_W  = DIV_W + 1;

    // Result format field positions inside result_format_mode.
    localparam int FM_RIGHT_BIT   = 0;
    localparam int FM_SIGNMAG_BIT = 1;

    // Left justification shifts applied when the result pair is read.
    localparam int LEFT_SHIFT_SE   = 4;
    localparam int LEFT_SHIFT_DIFF = 3;

    // Sign/magnitude layout: sign in bit 7 of the high byte, 11-bit magnitude.
    localparam int SIGN_POS = 15;
    localparam int MAG_W    = 11;

    // Sequencer constants.
    localparam logic [3:0]       BIT_FIRST = 4'hb;
    localparam logic [3:0]       BIT_LAST  = 4'h0;
    localparam logic [RES_W-1:0] TRIAL_MID = 12'h800;
    localparam logic [RES_W-1:0] MAG_MAX   = 12'h7ff;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_PENDING,
        PH_CONVERT
    } conv_phase_t;

endpackage

// ==== hdl/conv_clock_gen.sv ====
// Conversion clock generator: synchronised RC clock or divided system clock.
`timescale 1ns/100ps
`default_nettype none

module conv_clock_gen (
    // Clock and reset
    input  wire logic                         core_clk,
    input  wire logic                         rst_b,
    // Selection
    input  wire logic                         sel_rc,
    input  wire logic [conv_ctrl_pkg::DIV_W-1:0] clock_divider,
    input  wire logic                         internal_rc_clock,
    // Conversion clock enable
    output logic                              tick
);
    import conv_ctrl_pkg::*;

    typedef struct packed {
        logic             rc_meta;
        logic             rc_sync;
        logic             rc_prev;
        logic [CNT_W-1:0] cnt;
        logic             tick;
    } clkgen_state_t;

    clkgen_state_t    s;
    clkgen_state_t    next_s;
    logic [CNT_W-1:0] limit;

    // One conversion clock period spans 2*(divider+1) system clocks.
    assign limit = {clock_divider, 1'b1};

    always_comb begin
        next_s         = s;
        next_s.rc_meta = internal_rc_clock;
        next_s.rc_sync = s.rc_meta;
        next_s.rc_prev = s.rc_sync;
        next_s.tick    = 1'b0;
        if (sel_rc) begin
            next_s.cnt  = '0;
            next_s.tick = s.rc_sync & ~s.rc_prev;
        end else if (s.cnt >= limit) begin
            next_s.cnt  = '0;
            next_s.tick = 1'b1;
        end else begin
            next_s.cnt = s.cnt + 7'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;

    div_wrap_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (!sel_rc && s.cnt >= limit) |=> (tick && s.cnt == '0))
        else $error("divided conversion clock did not wrap at its limit");

    div_gap_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (!sel_rc && clock_divider == 6'h01 && tick && s.cnt == '0)
        ##1 (!sel_rc && clock_divider == 6'h01)
        |-> !tick [*3])
        else $error("divide by four produced ticks too close together");

endmodule

`default_nettype wire

// ==== verif/adc_clock_irq_result_format_test.sv ====
// Self-checking testbench of the converter control block.
`timescale 1ns/100ps
`default_nettype none

module adc_clock_irq_result_format_test;
    import conv_ctrl_pkg::*;

    logic              core_clk;
    logic              rst_b;
    logic              clock_source_rc;
    logic [DIV_W-1:0]  clock_divider;
    logic              input_configuration;
    logic [1:0]        result_format_mode;
    logic [REF_W-1:0]  positive_ref_select;
    logic              internal_rc_clock = 1'b0;
    logic              comparator_in = 1'b0;
    logic              conv_start;
    logic              sleep_mode;
    logic              conversion_irq_enable;
    logic              peripheral_irq_enable;
    logic              global_irq_enable;
    logic              flag_clear;
    logic              result_wr;
    logic [WORD_W-1:0] result_wdata;
    logic              conversion_done_flag;
    logic              irq_request;
    logic              wake_request;
    logic              isr_request;
    logic              conv_busy;
    logic [RES_W-1:0]  dac_trial;
    logic [REF_W-1:0]  reference_control;
    logic [7:0]        result_high_byte;
    logic [7:0]        result_low_byte;
    logic [RES_W-1:0]  target;
    int                rc_cnt = 0;
    int                error_cnt;
    int                n_tests;
    logic [2:0]        fmt_mode [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [15:0]       fmt_exp [6] = '{16'h1230, 16'h8123, 16'h0918, 16'h8123, 16'h8918, 16'h8123};

    conv_ctrl dut_u (
        .core_clk(core_clk), .rst_b(rst_b), .clock_source_rc(clock_source_rc),
        .clock_divider(clock_divider), .input_configuration(input_configuration),
        .result_format_mode(result_format_mode), .positive_ref_select(positive_ref_select),
        .internal_rc_clock(internal_rc_clock), .comparator_in(comparator_in),
        .conv_start(conv_start), .sleep_mode(sleep_mode),
        .conversion_irq_enable(conversion_irq_enable),
        .peripheral_irq_enable(peripheral_irq_enable), .global_irq_enable(global_irq_enable),
        .flag_clear(flag_clear), .result_wr(result_wr), .result_wdata(result_wdata),
        .conversion_done_flag(conversion_done_flag), .irq_request(irq_request),
        .wake_request(wake_request), .isr_request(isr_request), .conv_busy(conv_busy),
        .dac_trial(dac_trial), .reference_control(reference_control),
        .result_high_byte(result_high_byte), .result_low_byte(result_low_byte)
    );

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // The RC pin runs free at ten core cycles a period; the comparator keeps a trial
    // bit while the trial code does not exceed the analog target.
    always @(posedge core_clk) begin
        rc_cnt <= (rc_cnt == 4) ? 0 : rc_cnt + 1;
        if (rc_cnt == 4) begin
            internal_rc_clock <= ~internal_rc_clock;
        end
        comparator_in <= (dac_trial <= target);
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Long hold so that even the slowest tick of the old clock copies the settings.
    task automatic cfg(input logic rc, input logic [5:0] d, input logic ic, input logic [1:0] fm,
                       input logic [1:0] rs);
        clock_source_rc <= rc;
        clock_divider <= d;
        input_configuration <= ic;
        result_format_mode <= fm;
        positive_ref_select <= rs;
        cyc(300);
        check("reference", 16'(reference_control), 16'(rs));
    endtask

    task automatic start(input logic [11:0] t);
        target <= t;
        flag_clear <= 1'b1;
        cyc(1);
        flag_clear <= 1'b0;
        conv_start <= 1'b1;
        cyc(1);
        conv_start <= 1'b0;
    endtask

    task automatic wait_done();
        int i;
        for (i = 0; i < 4000 && conversion_done_flag !== 1'b1; i++) cyc(1);
        check("done flag", 16'(conversion_done_flag), 16'h0001);
        check("trial idle", 16'(dac_trial), 16'h0000);
        cyc(4);
    endtask

    task automatic result(input logic [15:0] exp);
        check("result pair", {result_high_byte, result_low_byte}, exp);
    endtask

    task automatic period(input logic rc, input logic [5:0] d, input int exp);
        int n;
        cfg(rc, d, 1'b0, 2'h1, d[1:0]);
        start(12'h000);
        for (n = 0; n < 400 && dac_trial !== 12'h800; n++) cyc(1);
        for (n = 0; n < 400 && dac_trial === 12'h800; n++) cyc(1);
        check("tick period", 16'(n), 16'(exp));
        wait_done();
    endtask

    initial begin
        cyc(60000);
        error_cnt++;
        $display("Error watchdog expired before the tests ended");
        conclude();
    end

    initial begin
        rst_b = 1'b0;
        {clock_source_rc, clock_divider, input_configuration, result_format_mode} = '0;
        {positive_ref_select, conv_start, sleep_mode} = '0;
        {conversion_irq_enable, peripheral_irq_enable, global_irq_enable, flag_clear} = '0;
        {result_wr, result_wdata, target, error_cnt, n_tests} = '0;
        cyc(16);
        rst_b <= 1'b1;
        cyc(2);
        check("idle outputs", {result_high_byte, result_low_byte}, 16'h0000);
        check("idle status", 16'({conversion_done_flag, irq_request, conv_busy}), 16'h0);
        $display("Test reset done");

        // Written words are stored right justified and viewed through each format.
        result_wr <= 1'b1;
        result_wdata <= 16'h8123;
        cyc(1);
        result_wr <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            cfg(1'b0, 6'h00, fmt_mode[i][2], fmt_mode[i][1:0], 2'(i));
            check("format view", {result_high_byte, result_low_byte}, fmt_exp[i]);
        end
        $display("Test formats done");

        period(1'b0, 6'h00, 2);
        period(1'b0, 6'h01, 4);
        period(1'b0, 6'h3f, 128);
        period(1'b1, 6'h3f, 10);
        $display("Test clock periods done");

        // Conversions whose results matter use an odd divider.
        cfg(1'b0, 6'h03, 1'b0, 2'h1, 2'h0);
        start(12'h5a3);
        wait_done();
        result(16'h05a3);
        check("irq masked", 16'(irq_request), 16'h0000);
        cyc(50);
        check("flag held", 16'(conversion_done_flag), 16'h0001);
        conversion_irq_enable <= 1'b1;
        cyc(3);
        check("irq", 16'(irq_request), 16'h0001);
        flag_clear <= 1'b1;
        cyc(1);
        flag_clear <= 1'b0;
        cyc(3);
        check("cleared", 16'({conversion_done_flag, irq_request}), 16'h0000);
        $display("Test flag and irq done");

        // A divided clock must not let the conversion run while sleeping.
        sleep_mode <= 1'b1;
        start(12'habc);
        cyc(400);
        check("frozen", 16'({conversion_done_flag, conv_busy}), 16'h0001);
        sleep_mode <= 1'b0;
        wait_done();
        result(16'h0abc);
        $display("Test sleep freeze done");

        cfg(1'b0, 6'h03, 1'b1, 2'h1, 2'h1);
        start(12'h7fe);
        wait_done();
        result(16'hfffe);
        start(12'h805);
        wait_done();
        result(16'h0005);
        $display("Test two's complement done");

        // The RC clock keeps converting in sleep and the completion wakes the core.
        cfg(1'b1, 6'h03, 1'b1, 2'h3, 2'h2);
        sleep_mode <= 1'b1;
        peripheral_irq_enable <= 1'b1;
        start(12'h7fe);
        wait_done();
        result(16'h8002);
        check("wake no isr", 16'({wake_request, isr_request}), 16'h0002);
        global_irq_enable <= 1'b1;
        cyc(3);
        check("wake and isr", 16'({wake_request, isr_request}), 16'h0003);
        sleep_mode <= 1'b0;
        cyc(3);
        check("awake", 16'(wake_request), 16'h0000);
        start(12'h803);
        wait_done();
        result(16'h0003);
        $display("Test rc sleep wake done");
        conclude();
    end
endmodule

`default_nettype wire
